//--- design/volume_loader_pkg.sv
`default_nettype none
package volume_loader_pkg;
    // ****************************************
    // word layout
    // ****************************************
    localparam int BYTE_W        = 8;
    localparam int FRAME_BITS    = 16;
    localparam int MASTER_W      = 7;
    localparam int CHAN_W        = 5;
    localparam int NUM_CHAN      = 6;
    localparam int TARGET_W      = 3;
    localparam int NET_W         = 9;
    localparam int ADDR_FLAG_BIT = 7;

    // ****************************************
    // target codes in the low bits of an address byte
    // ****************************************
    localparam logic [TARGET_W-1:0] TARGET_MASTER    = 3'h0;
    localparam logic [TARGET_W-1:0] TARGET_LAST_CHAN = 3'h6;

    // ****************************************
    // level codes and values after reset
    // ****************************************
    localparam logic [MASTER_W-1:0] MASTER_NO_ATTEN = 7'h7F;
    localparam logic [MASTER_W-1:0] MASTER_RESET    = 7'h00;
    localparam logic [CHAN_W-1:0]   CHAN_ZERO_GAIN  = 5'h1F;
    localparam logic [CHAN_W-1:0]   CHAN_RESET      = 5'h1F;
    localparam logic [CHAN_W-1:0]   BALANCE_CENTRE  = 5'h10;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS      = 5;
    localparam int SCLK_MIN_PERIOD_NS = 1000;
    localparam int SCLK_HALF_CYCLES   = (SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_W             = 8;
endpackage
`default_nettype wire

//--- design/serial_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
    logic sclk;
    logic sdata;
    logic shiftEn_n;
    logic load_strobe_n;

    modport host
    (
        output sclk,
        output sdata,
        output shiftEn_n,
        output load_strobe_n
    );

    modport dev
    (
        input sclk,
        input sdata,
        input shiftEn_n,
        input load_strobe_n
    );
endinterface
`default_nettype wire

//--- design/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync
#(
    parameter logic RESET_LEVEL = 1'b0
)
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic async,
    output logic      synced
);
    logic stage1;
    logic next_stage1;
    logic next_synced;

    always_comb
    begin
        next_stage1 = async;
        next_synced = stage1;
        if (sys_rst)
        begin
            next_stage1 = RESET_LEVEL;
            next_synced = RESET_LEVEL;
        end
    end

    always_ff @(posedge clk)
    begin
        stage1 <= next_stage1;
        synced <= next_synced;
    end
endmodule
`default_nettype wire

//--- design/volume_loader_dev.sv
// Notes on behaviour
// - each update is address byte, data byte, or a data byte alone for the held target
// - MSB one marks an address byte
// - MSB zero marks a data byte
// - master code 7F none, 00 full attenuation
// - channel code 00 max gain, 1F zero
// - host centres balance at 10h
// - shift edges accepted only while enable low
// - holding updated only at load strobe rise
// - MSB first, sampled on falling clock
// - host lowers both strobes, then raises both
// - host may tie both strobes together
// - serial clock no faster than 1 MHz
// - channel level combines own and master code
// - master holds 128 codes, channel 32
// - master mute active from power-up
`timescale 1ns/1ps
`default_nettype none
module volume_loader_dev
    import volume_loader_pkg::*;
(
    input  wire logic                                   clk,
    input  wire logic                                   sys_rst,
    serial_link_if.dev                                  link,
    output logic [MASTER_W-1:0]                         masterLevel,
    output logic [NUM_CHAN-1:0][CHAN_W-1:0]             chanLevel,
    output logic signed [NUM_CHAN-1:0][NET_W-1:0]       netLevel,
    output logic                                        masterMute,
    output logic                                        updatePulse
);
    // ****************************************
    // link side: runs on the serial clock
    // ****************************************
    logic [2:0]        bitCount;
    logic              inFrame;
    logic [BYTE_W-2:0] shiftReg;
    logic [BYTE_W-1:0] addrByte;
    logic [BYTE_W-1:0] dataByte;
    logic              addrSeen;
    logic              dataSeen;
    logic [2:0]        next_bitCount;
    logic              next_inFrame;
    logic [BYTE_W-2:0] next_shiftReg;
    logic [BYTE_W-1:0] next_addrByte;
    logic [BYTE_W-1:0] next_dataByte;
    logic              next_addrSeen;
    logic              next_dataSeen;
    logic [BYTE_W-1:0] byteNow;
    logic [2:0]        bitPos;

    always_comb
    begin
        bitPos        = inFrame ? bitCount : 3'h0;
        byteNow       = {shiftReg, link.sdata};
        next_inFrame  = 1'b1;
        next_bitCount = bitPos + 3'h1;
        next_shiftReg = byteNow[BYTE_W-2:0];
        next_addrByte = addrByte;
        next_dataByte = dataByte;
        // flags of an earlier frame are dropped at the first edge of a new one
        next_addrSeen = inFrame ? addrSeen : 1'b0;
        next_dataSeen = inFrame ? dataSeen : 1'b0;
        if (bitPos == 3'h7)
        begin
            if (byteNow[ADDR_FLAG_BIT])
            begin
                next_addrByte = byteNow;
                next_addrSeen = 1'b1;
            end
            else
            begin
                next_dataByte = byteNow;
                next_dataSeen = 1'b1;
            end
        end
    end

    // enable high holds the counter cleared, so stray clocks are ignored
    always_ff @(negedge link.sclk or posedge link.shiftEn_n)
    begin
        if (link.shiftEn_n)
        begin
            bitCount <= 3'h0;
            inFrame  <= 1'b0;
        end
        else
        begin
            bitCount <= next_bitCount;
            inFrame  <= next_inFrame;
        end
    end

    always_ff @(negedge link.sclk)
    begin
        if (!link.shiftEn_n)
        begin
            shiftReg <= next_shiftReg;
            addrByte <= next_addrByte;
            dataByte <= next_dataByte;
            addrSeen <= next_addrSeen;
            dataSeen <= next_dataSeen;
        end
    end

    // ****************************************
    // load strobe crossing into the system clock
    // ****************************************
    logic ldSync;
    logic ldDelay;
    logic next_ldDelay;
    logic ldRise;

    level_sync #(.RESET_LEVEL(1'b1)) u_load_sync
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .async   (link.load_strobe_n),
        .synced  (ldSync)
    );

    always_comb
    begin
        next_ldDelay = sys_rst ? 1'b1 : ldSync;
        ldRise       = ldSync & ~ldDelay;
    end

    always_ff @(posedge clk)
    begin
        ldDelay <= next_ldDelay;
    end

    // ****************************************
    // decode and holding registers
    // ****************************************
    logic [TARGET_W-1:0]            target;
    logic                           targetValid;
    logic [NUM_CHAN-1:0][CHAN_W-1:0] next_chanLevel;
    logic [MASTER_W-1:0]            next_masterLevel;
    logic [TARGET_W-1:0]            next_target;
    logic                           next_targetValid;
    logic                           next_masterMute;
    logic                           next_updatePulse;
    logic [TARGET_W-1:0]            useTarget;
    logic                           useValid;

    always_comb
    begin
        next_masterLevel = masterLevel;
        next_chanLevel   = chanLevel;
        next_target      = target;
        next_targetValid = targetValid;
        next_masterMute  = masterMute;
        next_updatePulse = 1'b0;
        useTarget        = target;
        useValid         = targetValid;
        // link registers are quiet here: the serial clock stops before the strobe rises
        if (ldRise)
        begin
            if (addrSeen)
            begin
                useTarget = addrByte[TARGET_W-1:0];
                useValid  = addrByte[TARGET_W-1:0] <= TARGET_LAST_CHAN;
            end
            next_target      = useTarget;
            next_targetValid = useValid;
            if (dataSeen && useValid)
            begin
                next_updatePulse = 1'b1;
                if (useTarget == TARGET_MASTER)
                begin
                    next_masterLevel = dataByte[MASTER_W-1:0];
                    next_masterMute  = 1'b0;
                end
                else
                begin
                    next_chanLevel[useTarget - 3'h1] = dataByte[CHAN_W-1:0];
                end
            end
        end
        if (sys_rst)
        begin
            next_masterLevel = MASTER_RESET;
            next_chanLevel   = {NUM_CHAN{CHAN_RESET}};
            next_target      = TARGET_MASTER;
            next_targetValid = 1'b0;
            next_masterMute  = 1'b1;
            next_updatePulse = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        masterLevel <= next_masterLevel;
        chanLevel   <= next_chanLevel;
        target      <= next_target;
        targetValid <= next_targetValid;
        masterMute  <= next_masterMute;
        updatePulse <= next_updatePulse;
    end

    // ****************************************
    // effective level per channel, in steps
    // ****************************************
    logic signed [NUM_CHAN-1:0][NET_W-1:0] next_netLevel;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++)
        begin : g_net
            logic [NET_W-1:0] gainSteps;
            logic [NET_W-1:0] attenSteps;
            always_comb
            begin
                gainSteps  = NET_W'(CHAN_ZERO_GAIN - chanLevel[ch]);
                attenSteps = NET_W'(MASTER_NO_ATTEN - masterLevel);
                next_netLevel[ch] = sys_rst ? '0 : gainSteps - attenSteps;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        netLevel <= next_netLevel;
    end
endmodule
`default_nettype wire

//--- design/volume_loader_host.sv
`timescale 1ns/1ps
`default_nettype none
module volume_loader_host
    import volume_loader_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                sys_rst,
    serial_link_if.host              link,
    input  wire logic                cmdValid,
    output logic                     cmdReady,
    input  wire logic [TARGET_W-1:0] cmdTarget,
    input  wire logic [MASTER_W-1:0] cmdCode,
    input  wire logic                cmdCentre
);
    typedef enum logic [2:0] {IDLE, LEAD, BIT_HIGH, BIT_LOW, TRAIL, GAP} host_state_t;

    host_state_t           state;
    host_state_t           next_state;
    logic [HALF_W-1:0]     halfCount;
    logic [HALF_W-1:0]     next_halfCount;
    logic [3:0]            bitIdx;
    logic [3:0]            next_bitIdx;
    logic [FRAME_BITS-1:0] frame;
    logic [FRAME_BITS-1:0] next_frame;
    logic                  next_sclk;
    logic                  next_sdata;
    logic                  next_strobe_n;
    logic                  halfDone;
    logic [MASTER_W-1:0]   code;

    assign cmdReady = (state == IDLE);

    always_comb
    begin
        halfDone       = halfCount == HALF_W'(SCLK_HALF_CYCLES - 1);
        code           = cmdCentre ? MASTER_W'(BALANCE_CENTRE) : cmdCode;
        next_state     = state;
        next_halfCount = halfDone ? '0 : halfCount + 8'h01;
        next_bitIdx    = bitIdx;
        next_frame     = frame;
        next_sclk      = 1'b1;
        next_strobe_n  = 1'b0;
        case (state)
            IDLE:
            begin
                next_strobe_n  = 1'b1;
                next_halfCount = '0;
                if (cmdValid)
                begin
                    // address byte then data byte, MSB first
                    next_frame    = {1'b1, 4'h0, cmdTarget, 1'b0, code};
                    next_bitIdx   = 4'h0;
                    next_state    = LEAD;
                    next_strobe_n = 1'b0;
                end
            end
            LEAD:
                if (halfDone)
                    next_state = BIT_HIGH;
            BIT_HIGH:
                if (halfDone)
                begin
                    next_state = BIT_LOW;
                    next_sclk  = 1'b0;
                end
            BIT_LOW:
            begin
                next_sclk = 1'b0;
                if (halfDone)
                begin
                    next_sclk = 1'b1;
                    if (bitIdx == 4'hF)
                        next_state = TRAIL;
                    else
                    begin
                        next_frame  = {frame[FRAME_BITS-2:0], 1'b0};
                        next_bitIdx = bitIdx + 4'h1;
                        next_state  = BIT_HIGH;
                    end
                end
            end
            TRAIL:
                if (halfDone)
                begin
                    next_state    = GAP;
                    next_strobe_n = 1'b1;
                end
            GAP:
            begin
                next_strobe_n = 1'b1;
                if (halfDone)
                    next_state = IDLE;
            end
            default:
                next_state = IDLE;
        endcase
        next_sdata = next_frame[FRAME_BITS-1];
        if (sys_rst)
        begin
            next_state     = IDLE;
            next_halfCount = '0;
            next_bitIdx    = 4'h0;
            next_frame     = '0;
            next_sclk      = 1'b1;
            next_sdata     = 1'b0;
            next_strobe_n  = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        state              <= next_state;
        halfCount          <= next_halfCount;
        bitIdx             <= next_bitIdx;
        frame              <= next_frame;
        link.sclk          <= next_sclk;
        link.sdata         <= next_sdata;
        link.shiftEn_n     <= next_strobe_n;
        link.load_strobe_n <= next_strobe_n;
    end
endmodule
`default_nettype wire

//--- bench/serial_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module serial_link_properties
    import volume_loader_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic shiftEn_n,
    input wire logic load_strobe_n
);
    logic [4:0]  fallCnt;
    logic [15:0] frame;
    logic [7:0]  halfCnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ****************************************
    // frame observers
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            fallCnt <= 5'h00;
            frame   <= 16'h0000;
            halfCnt <= 8'hFF;
        end
        else
        begin
            if (shiftEn_n)
                fallCnt <= 5'h00;
            else if ($fell(sclk))
                fallCnt <= fallCnt + 5'h01;
            if ($fell(sclk) && !shiftEn_n)
                frame <= {frame[14:0], sdata};
            if ($changed(sclk))
                halfCnt <= 8'h00;
            else if (halfCnt != 8'hFF)
                halfCnt <= halfCnt + 8'h01;
        end
    end

    // ****************************************
    // link checks
    // ****************************************
    idle_clock_high_a: assert property (shiftEn_n |-> sclk)
        else $error("serial clock low outside a frame");
    strobes_tied_a: assert property (load_strobe_n == shiftEn_n)
        else $error("load strobe differs from shift enable");
    bit_count_a: assert property ($rose(shiftEn_n) |-> fallCnt == 5'h10)
        else $error("frame without sixteen clock falls");
    byte_kinds_a: assert property ($rose(shiftEn_n) |-> frame[15] && frame[14:11] == 4'h0 && !frame[7])
        else $error("frame bytes in wrong order or form");
    data_steady_a: assert property (!sclk && !$past(sclk) |-> $stable(sdata))
        else $error("data changed while serial clock low");
    lead_in_a: assert property ($fell(shiftEn_n) |-> (sclk && sdata)[*8])
        else $error("clocking began right after strobes fell");
    clock_rate_a: assert property ($changed(sclk) |-> int'(halfCnt) >= SCLK_HALF_CYCLES - 1)
        else $error("serial clock half period too short");
    reset_idle_a: assert property ($fell(sys_rst) |-> shiftEn_n && load_strobe_n && sclk)
        else $error("link not idle at reset release");
endmodule
`default_nettype wire

//--- bench/serial_volume_level_loader_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_volume_level_loader_tb
    import volume_loader_pkg::*;
;
    logic                                  clk       = 1'h0;
    logic                                  sys_rst   = 1'h1;
    logic                                  cmdValid  = 1'h0;
    logic                                  cmdCentre = 1'h0;
    logic [TARGET_W-1:0]                   cmdTarget = 3'h0;
    logic [MASTER_W-1:0]                   cmdCode   = 7'h00;
    logic                                  cmdReady;
    logic [MASTER_W-1:0]                   masterLevel, masterLevel2, expMaster;
    logic [NUM_CHAN-1:0][CHAN_W-1:0]       chanLevel;
    logic signed [NUM_CHAN-1:0][NET_W-1:0] netLevel;
    logic                                  masterMute, masterMute2, updatePulse, updatePulse2, expMute, seen;
    logic [CHAN_W-1:0]                     expChan [NUM_CHAN];
    logic [MASTER_W-1:0]                   codes [2:6] = '{7'h1F, 7'h3F, 7'h0F, 7'h01, 7'h10};
    int                                    n_fail = 0;
    int                                    comparisons = 0;
    int                                    cycles = 0;

    serial_link_if link ();
    serial_link_if link2 ();

    volume_loader_host i_volume_loader_host (.clk(clk), .sys_rst(sys_rst), .link(link), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdTarget(cmdTarget), .cmdCode(cmdCode), .cmdCentre(cmdCentre));
    volume_loader_dev i_volume_loader_dev (.clk(clk), .sys_rst(sys_rst), .link(link), .masterLevel(masterLevel),
        .chanLevel(chanLevel), .netLevel(netLevel), .masterMute(masterMute), .updatePulse(updatePulse));
    // second device fed by a bench driver that breaks the framing on purpose
    volume_loader_dev i_volume_loader_dev_fault (.clk(clk), .sys_rst(sys_rst), .link(link2),
        .masterLevel(masterLevel2), .chanLevel(), .netLevel(), .masterMute(masterMute2), .updatePulse(updatePulse2));
    serial_link_properties i_serial_link_properties (.clk(clk), .sys_rst(sys_rst), .sclk(link.sclk),
        .sdata(link.sdata), .shiftEn_n(link.shiftEn_n), .load_strobe_n(link.load_strobe_n));

    always #2.5 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            n_fail++;
            $display("ERROR %0t timeout", $time);
            summarize();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic summarize;
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic checkAll;
        for (int i = 0; i < NUM_CHAN; i++)
        begin
            chk(9'(chanLevel[i]), 9'(expChan[i]), "channel");
            chk(netLevel[i], 9'(int'(CHAN_ZERO_GAIN) - expChan[i] - int'(MASTER_NO_ATTEN) + expMaster), "net");
        end
        chk(9'(masterLevel), 9'(expMaster), "master");
        chk(9'(masterMute), 9'(expMute), "mute");
    endtask

    task automatic waitUp(input logic two, output logic got);
        got = 1'h0;
        for (int k = 0; k < 4500 && got !== 1'h1; k++)
        begin
            @(posedge clk);
            #1;
            got = two ? updatePulse2 : updatePulse;
        end
    endtask

    task automatic wr(input logic [TARGET_W-1:0] t, input logic [MASTER_W-1:0] c, input logic ctr);
        logic got;
        for (int k = 0; k < 5000 && cmdReady !== 1'h1; k++)
        begin
            @(posedge clk);
            #1;
        end
        cmdTarget = t;
        cmdCode   = c;
        cmdCentre = ctr;
        cmdValid  = 1'h1;
        @(posedge clk);
        #1;
        cmdValid = 1'h0;
        chk(9'(cmdReady), 9'h000, "busy");
        chk(9'(link.shiftEn_n), 9'h000, "strobe low");
        if (t == TARGET_MASTER)
        begin
            expMaster = c;
            expMute   = 1'h0;
        end
        else if (t <= TARGET_LAST_CHAN)
            expChan[t - 1] = ctr ? BALANCE_CENTRE : c[CHAN_W-1:0];
        waitUp(1'h0, got);
        chk(9'(got), 9'(t <= TARGET_LAST_CHAN), "pulse");
        @(posedge clk);
        #1;
        checkAll();
    endtask

    task automatic rawFrame(input logic [15:0] v, input int n, input logic en);
        @(posedge clk);
        #1;
        if (en)
        begin
            link2.shiftEn_n     = 1'h0;
            link2.load_strobe_n = 1'h0;
        end
        #80;
        for (int i = 15; i > 15 - n; i--)
        begin
            link2.sdata = v[i];
            #80;
            link2.sclk = 1'h0;
            #80;
            link2.sclk = 1'h1;
        end
    endtask

    task automatic rawEnd;
        #80;
        link2.shiftEn_n     = 1'h1;
        link2.load_strobe_n = 1'h1;
        link2.sdata         = ~link2.sdata;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        link2.sclk          = 1'h1;
        link2.sdata         = 1'h0;
        // low at start, so the raise below clears the fault device's bit counter
        link2.shiftEn_n     = 1'h0;
        link2.load_strobe_n = 1'h1;
        expMaster           = MASTER_RESET;
        expMute             = 1'h1;
        foreach (expChan[i])
            expChan[i] = CHAN_RESET;
        repeat (4) @(posedge clk);
        #1;
        sys_rst         = 1'h0;
        link2.shiftEn_n = 1'h1;
        repeat (2) @(posedge clk);
        #1;
        checkAll();
        wr(3'h1, 7'h00, 1'h0);
        wr(TARGET_MASTER, MASTER_NO_ATTEN, 1'h0);
        for (int t = 2; t <= 6; t++)
            wr(3'(t), codes[t], t == 3);
        wr(TARGET_MASTER, 7'h00, 1'h0);
        wr(3'h7, 7'h55, 1'h0);
        wr(TARGET_MASTER, 7'h40, 1'h0);
        rawFrame(16'h0500, 8, 1'h1);
        rawEnd();
        waitUp(1'h1, seen);
        chk(9'(seen), 9'h000, "orphan pulse");
        chk(9'(masterLevel2), 9'(MASTER_RESET), "orphan master");
        // twelve stray clocks would leave a frame misaligned if enable were ignored
        rawFrame(16'hFFFF, 12, 1'h0);
        rawFrame(16'h8011, 16, 1'h1);
        repeat (8) @(posedge clk);
        #1;
        chk(9'(masterLevel2), 9'(MASTER_RESET), "early load");
        rawEnd();
        waitUp(1'h1, seen);
        chk(9'(seen), 9'h001, "framed pulse");
        chk(9'(masterLevel2), 9'h011, "framed master");
        chk(9'(masterMute2), 9'h000, "mute off");
        rawFrame(16'h2200, 8, 1'h1);
        rawEnd();
        waitUp(1'h1, seen);
        chk(9'(seen), 9'h001, "kept pulse");
        chk(9'(masterLevel2), 9'h022, "address kept");
        summarize();
    end
endmodule
`default_nettype wire
